/* File: logic/msc_pkg.sv */
// Constants shared by the mode and system control block.
package msc_pkg;

  // ----------------------------------------------------------------
  // Register bus geometry and offsets
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] OFS_MODE_MON = 4'h0;
  localparam logic [3:0] OFS_SYS_CTRL = 4'h1;
  localparam logic [3:0] OFS_PIN_FUNC = 4'h2;
  localparam logic [3:0] OFS_P1_DIR = 4'h3;
  localparam logic [3:0] OFS_PA_DIR = 4'h4;
  localparam logic [3:0] OFS_PB_DIR = 4'h5;

  // ----------------------------------------------------------------
  // Operating mode monitor layout
  // ----------------------------------------------------------------
  localparam logic [4:0] MON_HIGH_BITS = 5'h10;
  localparam int MON_SEL_W = 3;
  localparam logic [2:0] MODE_SEL_RESET = 3'h0;

  // ----------------------------------------------------------------
  // System control layout
  // ----------------------------------------------------------------
  localparam int SYS_IRQ_HI = 5;
  localparam int SYS_IRQ_LO = 4;
  localparam int SYS_NMI_EDGE = 3;
  localparam int SYS_MANUAL_RESET_PIN_EN = 2;
  localparam int SYS_RAM_EN = 0;
  localparam logic [7:0] SYS_RESET = 8'h01;
  localparam logic [7:0] SYS_WMASK = 8'hbd;
  localparam logic [1:0] IRQ_MODE0 = 2'h0;
  localparam logic [1:0] IRQ_MODE2 = 2'h2;

  // ----------------------------------------------------------------
  // Pin function and direction resets
  // ----------------------------------------------------------------
  localparam int AE_W = 4;
  localparam logic [3:0] AE_RESET = 4'h0;
  localparam logic [3:0] DIR4_RESET = 4'h0;
  localparam logic [7:0] DIR8_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Operating modes and synchroniser depth
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_4 = 3'h4;
  localparam logic [2:0] MODE_7 = 3'h7;
  localparam int SYNC_STAGES = 2;

endpackage

/* File: logic/msc_strap_if.sv */
// Carrier between the register bank and the mode strap capture.
`timescale 1ns/10ps
interface msc_strap_if;
  logic [2:0] live_mode;
  logic [2:0] captured_mode;
  logic capture_req;

  modport capture (
    output live_mode,
    output captured_mode,
    input capture_req
  );
  modport bank (
    input live_mode,
    input captured_mode,
    output capture_req
  );
endinterface

/* File: logic/msc_strap_capture.sv */
// Mode strap synchroniser and the latch behind the mode select bits.
`timescale 1ns/10ps
module msc_strap_capture (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [2:0] strap_pins_in,
  msc_strap_if.capture strap
);

  // ----------------------------------------------------------------
  // Synchroniser and latch
  // ----------------------------------------------------------------
  logic [2:0] meta_ff;
  logic [2:0] live_ff;
  logic [2:0] latch_ff;
  logic [2:0] nxt_latch;

  // Only the power-on reset reaches this latch; a manual reset does not.
  always_comb begin
    nxt_latch = latch_ff;
    if (!nrst_in) begin
      nxt_latch = msc_pkg::MODE_SEL_RESET;
    end else if (strap.capture_req) begin
      nxt_latch = live_ff;
    end
  end

  always_ff @(posedge clk_in) begin
    meta_ff <= strap_pins_in;
    live_ff <= meta_ff;
    latch_ff <= nxt_latch;
  end

  assign strap.live_mode = live_ff;
  assign strap.captured_mode = latch_ff;

endmodule

/* File: logic/msc_top.sv */
// Operating mode monitor, system control register and mode 4 pin roles.
`timescale 1ns/10ps

// Summary of operation
// - Monitor bit 7 reads one, ignores writes.
// - Monitor bits 6 to 3 read zero.
// - Monitor bits 2 to 0 show strap pins.
// - Power-on clears latch, manual reset keeps it.
// - Control bits 6 and 1 read zero.
// - Interrupt mode field resets 00, 10 mode 2.
// - Edge select picks falling or rising nonmaskable edge.
// - Manual reset pin honoured only when enabled.
// - RAM enable resets one, software toggles it.
// - RAM enable restored when reset releases.
// - Mode 4 is advanced, ROM disabled.
// - Mode 4 ports carry address, data, control.
// - After reset upper port 1 pins input.
// - Top address lines gated by enable field.
// - Disabled address pin becomes output by direction.
// - In mode 4 port C always drives low address.
// - Mode 4 bus 16 bits unless all 8.
// - Modes 6 to 4 allow external access.
module msc_top (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [2:0] mode_strap_pins_in,
  input wire logic nmi_pin_in,
  input wire logic manual_reset_pin_n_in,
  input wire logic bus_all_8bit_in,
  output logic [7:0] rd_data_out,
  output logic [2:0] mode_select_out,
  output logic [1:0] irq_ctrl_mode_out,
  output logic nonmaskable_edge_select_out,
  output logic manual_reset_enable_out,
  output logic onchip_ram_enable_out,
  output logic nmi_req_out,
  output logic manual_reset_out,
  output logic mode4_out,
  output logic ext_bus_allowed_out,
  output logic rom_enable_out,
  output logic advanced_mode_out,
  output logic bus16_out,
  output logic [3:0] port1_low_pins_addr_out,
  output logic [3:0] port1_low_pins_oe_out,
  output logic [3:0] porta_addr_out,
  output logic [3:0] porta_oe_out,
  output logic [7:0] portb_addr_out,
  output logic [7:0] portb_oe_out,
  output logic portc_addr_out,
  output logic portde_data_out,
  output logic portf_ctrl_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [7:0] mon_word(input logic [2:0] lvl);
    mon_word = {msc_pkg::MON_HIGH_BITS, lvl};
  endfunction

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  msc_strap_if strap ();

  msc_strap_capture u_strap (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .strap_pins_in(mode_strap_pins_in),
    .strap(strap.capture)
  );

  // The live strap levels are trusted to stay put while running.
  assign strap.capture_req = rd_in && hit(addr_in, msc_pkg::OFS_MODE_MON);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic nmi_meta_ff;
  logic nmi_sync_ff;
  logic nmi_prev_ff;
  logic manual_reset_pin_meta_ff;
  logic manual_reset_pin_sync_ff;

  always_ff @(posedge clk_in) begin
    nmi_meta_ff <= nmi_pin_in;
    nmi_sync_ff <= nmi_meta_ff;
    nmi_prev_ff <= nmi_sync_ff;
    manual_reset_pin_meta_ff <= manual_reset_pin_n_in;
    manual_reset_pin_sync_ff <= manual_reset_pin_meta_ff;
  end

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  logic [7:0] sys_ctrl_ff;
  logic [3:0] pin_func_ff;
  logic [3:0] p1_dir_ff;
  logic [3:0] pa_dir_ff;
  logic [7:0] pb_dir_ff;
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_sys_ctrl;
  logic [3:0] nxt_pin_func;
  logic [3:0] nxt_p1_dir;
  logic [3:0] nxt_pa_dir;
  logic [7:0] nxt_pb_dir;
  logic [7:0] nxt_rd_data;
  logic manual_reset_pin_active;

  // The enable bit itself survives a manual reset, otherwise the reset
  // would drop itself after one cycle while the pin is still low.
  assign manual_reset_pin_active = sys_ctrl_ff[msc_pkg::SYS_MANUAL_RESET_PIN_EN] && !manual_reset_pin_sync_ff;

  always_comb begin
    nxt_sys_ctrl = sys_ctrl_ff;
    nxt_pin_func = pin_func_ff;
    nxt_p1_dir = p1_dir_ff;
    nxt_pa_dir = pa_dir_ff;
    nxt_pb_dir = pb_dir_ff;
    nxt_rd_data = 8'h00;
    if (!nrst_in) begin
      nxt_sys_ctrl = msc_pkg::SYS_RESET;
      nxt_pin_func = msc_pkg::AE_RESET;
      nxt_p1_dir = msc_pkg::DIR4_RESET;
      nxt_pa_dir = msc_pkg::DIR4_RESET;
      nxt_pb_dir = msc_pkg::DIR8_RESET;
    end else if (manual_reset_pin_active) begin
      nxt_sys_ctrl = msc_pkg::SYS_RESET;
      nxt_sys_ctrl[msc_pkg::SYS_MANUAL_RESET_PIN_EN] = 1'b1;
      nxt_pin_func = msc_pkg::AE_RESET;
      nxt_p1_dir = msc_pkg::DIR4_RESET;
      nxt_pa_dir = msc_pkg::DIR4_RESET;
      nxt_pb_dir = msc_pkg::DIR8_RESET;
    end else begin
      if (wr_in) begin
        // Bit 7 is stored as written; software keeps it at zero.
        if (hit(addr_in, msc_pkg::OFS_SYS_CTRL)) begin
          nxt_sys_ctrl = wr_data_in & msc_pkg::SYS_WMASK;
        end
        if (hit(addr_in, msc_pkg::OFS_PIN_FUNC)) begin
          nxt_pin_func = wr_data_in[3:0];
        end
        if (hit(addr_in, msc_pkg::OFS_P1_DIR)) begin
          nxt_p1_dir = wr_data_in[3:0];
        end
        if (hit(addr_in, msc_pkg::OFS_PA_DIR)) begin
          nxt_pa_dir = wr_data_in[3:0];
        end
        if (hit(addr_in, msc_pkg::OFS_PB_DIR)) begin
          nxt_pb_dir = wr_data_in;
        end
      end
      if (rd_in) begin
        case (addr_in)
          msc_pkg::OFS_MODE_MON: begin
            nxt_rd_data = mon_word(strap.live_mode);
          end
          msc_pkg::OFS_SYS_CTRL: begin
            nxt_rd_data = sys_ctrl_ff;
          end
          msc_pkg::OFS_PIN_FUNC: begin
            nxt_rd_data = {4'h0, pin_func_ff};
          end
          msc_pkg::OFS_P1_DIR: begin
            nxt_rd_data = {4'h0, p1_dir_ff};
          end
          msc_pkg::OFS_PA_DIR: begin
            nxt_rd_data = {4'h0, pa_dir_ff};
          end
          msc_pkg::OFS_PB_DIR: begin
            nxt_rd_data = pb_dir_ff;
          end
          default: begin
            nxt_rd_data = 8'h00;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_in) begin
    sys_ctrl_ff <= nxt_sys_ctrl;
    pin_func_ff <= nxt_pin_func;
    p1_dir_ff <= nxt_p1_dir;
    pa_dir_ff <= nxt_pa_dir;
    pb_dir_ff <= nxt_pb_dir;
    rd_data_ff <= nxt_rd_data;
  end

  // ----------------------------------------------------------------
  // Nonmaskable edge and manual reset
  // ----------------------------------------------------------------
  logic nmi_req_ff;
  logic manual_reset_pin_out_ff;
  logic nxt_nmi_req;
  logic nxt_manual_reset_pin_out;

  always_comb begin
    nxt_nmi_req = 1'b0;
    nxt_manual_reset_pin_out = 1'b0;
    if (nrst_in) begin
      if (sys_ctrl_ff[msc_pkg::SYS_NMI_EDGE]) begin
        nxt_nmi_req = nmi_sync_ff && !nmi_prev_ff;
      end else begin
        nxt_nmi_req = !nmi_sync_ff && nmi_prev_ff;
      end
      nxt_manual_reset_pin_out = manual_reset_pin_active;
    end
  end

  always_ff @(posedge clk_in) begin
    nmi_req_ff <= nxt_nmi_req;
    manual_reset_pin_out_ff <= nxt_manual_reset_pin_out;
  end

  // ----------------------------------------------------------------
  // Mode decode and pin roles
  // ----------------------------------------------------------------
  logic mode4_ff;
  logic ext_ff;
  logic rom_ff;
  logic adv_ff;
  logic bus16_ff;
  logic [3:0] p1_addr_ff;
  logic [3:0] p1_oe_ff;
  logic [3:0] pa_addr_ff;
  logic [3:0] pa_oe_ff;
  logic [7:0] pb_addr_ff;
  logic [7:0] pb_oe_ff;
  logic pc_addr_ff;
  logic pde_ff;
  logic pf_ff;
  logic nxt_mode4;
  logic nxt_ext;
  logic nxt_rom;
  logic nxt_bus16;
  logic [3:0] nxt_p1_addr;
  logic [3:0] nxt_pa_addr;
  logic [7:0] nxt_pb_addr;

  always_comb begin
    nxt_mode4 = nrst_in && (strap.live_mode == msc_pkg::MODE_4);
    // Codes below mode 4 are not valid straps and are treated as mode 7.
    nxt_ext = nrst_in && strap.live_mode[2] && (strap.live_mode != msc_pkg::MODE_7);
    nxt_rom = !nxt_mode4;
    nxt_bus16 = nxt_mode4 && !bus_all_8bit_in;
    nxt_p1_addr = 4'h0;
    nxt_pa_addr = 4'h0;
    nxt_pb_addr = 8'h00;
    if (nxt_mode4) begin
      // Upper lines follow the enable field, cleared by reset.
      nxt_p1_addr = {pin_func_ff[2:0], 1'b1};
      nxt_pa_addr = 4'hf;
      nxt_pb_addr = 8'hff;
    end
  end

  always_ff @(posedge clk_in) begin
    mode4_ff <= nxt_mode4;
    ext_ff <= nxt_ext;
    rom_ff <= nxt_rom;
    adv_ff <= nrst_in;
    bus16_ff <= nxt_bus16;
    p1_addr_ff <= nxt_p1_addr;
    p1_oe_ff <= nxt_p1_addr | p1_dir_ff;
    pa_addr_ff <= nxt_pa_addr;
    pa_oe_ff <= nxt_pa_addr | pa_dir_ff;
    pb_addr_ff <= nxt_pb_addr;
    pb_oe_ff <= nxt_pb_addr | pb_dir_ff;
    pc_addr_ff <= nxt_mode4;
    pde_ff <= nxt_mode4;
    pf_ff <= nxt_mode4;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data_out = rd_data_ff;
  assign mode_select_out = strap.captured_mode;
  assign irq_ctrl_mode_out = sys_ctrl_ff[msc_pkg::SYS_IRQ_HI:msc_pkg::SYS_IRQ_LO];
  assign nonmaskable_edge_select_out = sys_ctrl_ff[msc_pkg::SYS_NMI_EDGE];
  assign manual_reset_enable_out = sys_ctrl_ff[msc_pkg::SYS_MANUAL_RESET_PIN_EN];
  assign onchip_ram_enable_out = sys_ctrl_ff[msc_pkg::SYS_RAM_EN];
  assign nmi_req_out = nmi_req_ff;
  assign manual_reset_out = manual_reset_pin_out_ff;
  assign mode4_out = mode4_ff;
  assign ext_bus_allowed_out = ext_ff;
  assign rom_enable_out = rom_ff;
  assign advanced_mode_out = adv_ff;
  assign bus16_out = bus16_ff;
  assign port1_low_pins_addr_out = p1_addr_ff;
  assign port1_low_pins_oe_out = p1_oe_ff;
  assign porta_addr_out = pa_addr_ff;
  assign porta_oe_out = pa_oe_ff;
  assign portb_addr_out = pb_addr_ff;
  assign portb_oe_out = pb_oe_ff;
  assign portc_addr_out = pc_addr_ff;
  assign portde_data_out = pde_ff;
  assign portf_ctrl_out = pf_ff;

endmodule

/* File: sim/msc_top_props.sv */
// Concurrent checks on the mode and system control ports.
`timescale 1ns/10ps
module msc_top_props (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [3:0] addr_in,
  input wire logic rd_in,
  input wire logic nmi_pin_in,
  input wire logic bus_all_8bit_in,
  input wire logic [7:0] rd_data_out,
  input wire logic [2:0] mode_select_out,
  input wire logic [1:0] irq_ctrl_mode_out,
  input wire logic nonmaskable_edge_select_out,
  input wire logic manual_reset_enable_out,
  input wire logic onchip_ram_enable_out,
  input wire logic nmi_req_out,
  input wire logic manual_reset_out,
  input wire logic mode4_out,
  input wire logic rom_enable_out,
  input wire logic bus16_out,
  input wire logic [3:0] porta_addr_out,
  input wire logic portc_addr_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // ------------------------------------------------------------
  // Register reads, select latch hold and reset release values
  // ------------------------------------------------------------
  a_mon_fixed_bits: assert property (rd_in && addr_in == 4'h0 |=> rd_data_out[7:3] == 5'h10)
    else $error("monitor fixed bits wrong");
  a_mon_sel_match: assert property (rd_in && addr_in == 4'h0 |=> rd_data_out[2:0] == mode_select_out)
    else $error("monitor select bits differ from latch");
  a_sel_hold: assert property (!(rd_in && addr_in == 4'h0) |=> $stable(mode_select_out))
    else $error("mode select changed without a read");
  a_sys_reserved: assert property (rd_in && addr_in == 4'h1 |=> !rd_data_out[6] && !rd_data_out[1])
    else $error("control reserved bits not zero");
  a_sys_fields: assert property (rd_in && addr_in == 4'h1 |=> rd_data_out[5:0] ==
    {irq_ctrl_mode_out, nonmaskable_edge_select_out, manual_reset_enable_out, 1'b0, onchip_ram_enable_out})
    else $error("control read differs from outputs");
  a_ram_on_release: assert property ($rose(nrst_in) |-> onchip_ram_enable_out && irq_ctrl_mode_out == 2'h0)
    else $error("control not at reset value on release");
  // ------------------------------------------------------------
  // Pins and mode roles
  // ------------------------------------------------------------
  a_nmi_fall: assert property ($fell(nmi_pin_in) && !nonmaskable_edge_select_out |-> ##3 nmi_req_out)
    else $error("no request on falling edge");
  a_nmi_rise: assert property ($rose(nmi_pin_in) && nonmaskable_edge_select_out |-> ##3 nmi_req_out)
    else $error("no request on rising edge");
  a_manual_reset_pin_gated: assert property (manual_reset_out |-> $past(manual_reset_enable_out))
    else $error("manual reset while disabled");
  a_rom_off_mode4: assert property (mode4_out |-> !rom_enable_out)
    else $error("rom enabled in mode 4");
  a_bus_narrow: assert property (bus_all_8bit_in ##1 bus_all_8bit_in |-> !bus16_out)
    else $error("bus wide with all areas 8 bit");
  a_bus_wide: assert property (mode4_out && !bus_all_8bit_in ##1 mode4_out && !bus_all_8bit_in |-> bus16_out)
    else $error("bus narrow in mode 4");
  a_low_addr_roles: assert property (mode4_out ##1 mode4_out |-> portc_addr_out && porta_addr_out == 4'hf)
    else $error("address roles missing in mode 4");
  c_mon_read: cover property (rd_in && addr_in == 4'h0);
  c_nmi_pulse: cover property (nmi_req_out);
  c_manual_reset: cover property (manual_reset_out);
endmodule

bind msc_top msc_top_props i_props (.*);

/* File: sim/msc_board_model.sv */
// Board side: strap pins, interrupt pin and manual reset pin.
`timescale 1ns/10ps
module msc_board_model #(
  parameter logic [2:0] STRAPS = 3'h4
) (
  input wire logic clk_in,
  output logic [2:0] mode_strap_pins_out,
  output logic nmi_pin_out,
  output logic manual_reset_pin_n_out
);
  // Straps are fixed for the whole run; no task changes them.
  initial begin
    mode_strap_pins_out = STRAPS;
    nmi_pin_out = 1'b1;
    manual_reset_pin_n_out = 1'b1;
  end
  task automatic set_nmi(input logic v);
    @(posedge clk_in);
    nmi_pin_out <= v;
  endtask
  task automatic set_manual_reset_pin_n(input logic v);
    @(posedge clk_in);
    manual_reset_pin_n_out <= v;
  endtask
endmodule

/* File: sim/msc_top_tb.sv */
// Self-checking bench for the mode and system control block.
`timescale 1ns/10ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
  $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module msc_top_tb;
  logic clk_in, nrst_in, wr_in, rd_in, bus_all_8bit_in, nmi_pin_in, manual_reset_pin_n_in;
  logic [7:0] rd_data_out, wr_data_in, portb_addr_out, portb_oe_out;
  logic [3:0] addr_in, port1_low_pins_addr_out, port1_low_pins_oe_out, porta_addr_out, porta_oe_out;
  logic [2:0] mode_strap_pins_in, mode_select_out;
  logic [1:0] irq_ctrl_mode_out;
  logic nonmaskable_edge_select_out, manual_reset_enable_out, onchip_ram_enable_out, nmi_req_out;
  logic manual_reset_out, mode4_out, ext_bus_allowed_out, rom_enable_out, advanced_mode_out;
  logic bus16_out, portc_addr_out, portde_data_out, portf_ctrl_out;
  int error_cnt, check_count, cycles, pulses;
  msc_top i_dut (.*);
  msc_board_model i_board (.clk_in, .mode_strap_pins_out(mode_strap_pins_in), .nmi_pin_out(nmi_pin_in),
    .manual_reset_pin_n_out(manual_reset_pin_n_in));
  // ------------------------------------------------------------
  // Clock, watchdog and bus tasks
  // ------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // The whole sequence needs about a hundred cycles; the ceiling leaves ample margin.
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (nmi_req_out === 1'b1) pulses <= pulses + 1;
    if (cycles == 3000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic conclude();
    $display("Checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rd_data_out;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] v;
    int p;
    {wr_in, rd_in, bus_all_8bit_in, addr_in, wr_data_in} = '0;
    {error_cnt, check_count, cycles, pulses} = '0;
    nrst_in = 1'b0;
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
    cyc(4);
    rd(4'h1, v);
    `CHK(v, 8'h01)
    `CHK({rom_enable_out, mode4_out, advanced_mode_out, bus16_out}, 4'h7)
    `CHK({porta_addr_out, portb_addr_out, port1_low_pins_addr_out}, 16'hfff1)
    `CHK({portc_addr_out, portde_data_out, portf_ctrl_out, ext_bus_allowed_out}, 4'hf)
    `CHK({porta_oe_out, portb_oe_out}, 12'hfff)
    `CHK(mode_select_out, 3'h0)
    wr(4'h0, 8'h7b);
    rd(4'h0, v);
    `CHK(v, 8'h84)
    `CHK(mode_select_out, 3'h4)
    wr(4'h1, 8'h6f);
    rd(4'h1, v);
    `CHK(v, 8'h2d)
    `CHK({irq_ctrl_mode_out, nonmaskable_edge_select_out, manual_reset_enable_out, onchip_ram_enable_out}, 5'h17)
    wr(4'h1, 8'h00);
    `CHK({irq_ctrl_mode_out, onchip_ram_enable_out}, 3'h0)
    @(posedge clk_in);
    bus_all_8bit_in <= 1'b1;
    cyc(3);
    `CHK(bus16_out, 1'b0)
    @(posedge clk_in);
    bus_all_8bit_in <= 1'b0;
    cyc(3);
    `CHK(bus16_out, 1'b1)
    wr(4'h2, 8'h07);
    cyc(1);
    `CHK(port1_low_pins_addr_out, 4'hf)
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h0e);
    cyc(1);
    `CHK({port1_low_pins_addr_out, port1_low_pins_oe_out}, 8'h1f)
    rd(4'h3, v);
    `CHK(v, 8'h0e)
    rd(4'hf, v);
    `CHK(v, 8'h00)
    // Edge select 0 then 1; the final falling edge must be ignored.
    for (int e = 0; e < 2; e++) begin
      wr(4'h1, {4'h0, e[0], 3'h1});
      p = pulses;
      i_board.set_nmi(e[0]);
      cyc(5);
      `CHK(pulses - p, 1)
    end
    p = pulses;
    i_board.set_nmi(1'b0);
    cyc(5);
    `CHK(pulses - p, 0)
    i_board.set_manual_reset_pin_n(1'b0);
    cyc(5);
    `CHK(manual_reset_out, 1'b0)
    i_board.set_manual_reset_pin_n(1'b1);
    wr(4'h1, 8'h04);
    i_board.set_manual_reset_pin_n(1'b0);
    cyc(5);
    `CHK(manual_reset_out, 1'b1)
    i_board.set_manual_reset_pin_n(1'b1);
    cyc(5);
    rd(4'h1, v);
    `CHK(v, 8'h05)
    `CHK({mode_select_out, port1_low_pins_oe_out}, 7'h41)
    @(posedge clk_in);
    nrst_in <= 1'b0;
    cyc(3);
    `CHK(mode_select_out, 3'h0)
    @(posedge clk_in);
    nrst_in <= 1'b1;
    cyc(4);
    `CHK(onchip_ram_enable_out, 1'b1)
    conclude();
  end
endmodule
